// ### ewsg_pkg.sv
package ewsg_pkg;
   localparam logic [15:0] WSC_ADDR       = 16'hffff;
   localparam int          WSC_WIDTH      = 16;
   localparam int          WAIT_W         = 3;
   localparam int          PSW_LSB        = 0;
   localparam int          DSW_LSB        = 3;
   localparam int          ISW_LSB        = 6;
   localparam int          BUS_VISIBILITY_SELECT_LSB       = 9;
   localparam int          BUS_VISIBILITY_SELECT_EN_BIT    = 10;
   localparam int          BUS_VISIBILITY_SELECT_PROG_BIT  = 9;
   localparam int          IMPL_BITS      = 11;
   localparam logic [10:0] WSC_RESET      = 11'h7ff;
   localparam logic [1:0]  SPACE_PROG     = 2'h0;
   localparam logic [1:0]  SPACE_DATA     = 2'h1;
   localparam logic [1:0]  SPACE_IO       = 2'h2;
   localparam logic [2:0]  WAIT_ZERO      = 3'h0;

   typedef enum logic [2:0]
   {
      EWSG_IDLE = 3'b001,
      EWSG_WAIT = 3'b010,
      EWSG_DONE = 3'b100
   } ewsg_state_t;
endpackage

// ### ewsg_wait_state_gen.sv
`timescale 1ns/100ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Function
// RULE1: software picks zero to seven wait states per external space
// RULE2: three 3-bit wait fields: data, program and io space
// RULE3: programmed waits always inserted, whatever the ready level
// RULE4: ready low adds cycles; access never shorter than programmed count
// RULE5: every implemented config bit resets to one
// RULE6: config register sits at io address ffff
// RULE7: each wait field is a plain binary count
// RULE8: bits 2-0 set program space waits
// RULE9: bits 5-3 set data space waits
// RULE10: bits 8-6 set io space waits
// RULE11: visibility field bits 10-9 resets to 11, showing program buses
// RULE12: visibility only while executing from internal memory
// RULE13: bit 10 clear means no internal bus on the pins
// RULE14: bits 10,9 = 10 drive data address and data buses out
// RULE15: bits 10,9 = 11 drive program address and data buses out
// RULE16: bits 15-11 reserved, read as zero
// RULE17: one clock per wait state; new value used from next access
module ewsg_wait_state_gen
(
   // clock and reset
   input  wire logic        clock,
   input  wire logic        reset,
   // cpu io-space register port
   input  wire logic        io_sel,
   input  wire logic        io_wr,
   input  wire logic [15:0] io_addr,
   input  wire logic [15:0] io_wdata,
   output var  logic [15:0] io_rdata,
   // cpu external access request
   input  wire logic        ext_start,
   input  wire logic [1:0]  ext_space,
   output var  logic        ext_busy,
   output var  logic        ext_done,
   // ready pin from external logic
   input  wire logic        ready_pin,
   // internal buses for visibility
   input  wire logic        int_exec,
   input  wire logic [15:0] prog_addr,
   input  wire logic [15:0] prog_data,
   input  wire logic [15:0] data_addr,
   input  wire logic [15:0] data_data,
   // external pin drive for visibility
   output var  logic [15:0] vis_addr,
   output var  logic [15:0] vis_data,
   output var  logic        vis_oe,
   // configuration fields seen by the bus unit
   output var  logic [2:0]  program_space_waits,
   output var  logic [2:0]  data_space_waits,
   output var  logic [2:0]  io_space_waits,
   output var  logic [1:0]  bus_visibility_select
);

   ////////////////////////////////////////////////////////////////////////////////
   // configuration register
   logic [10:0] cfg_q, cfg_d;
   logic        cfg_hit;

   always_comb
   begin
      cfg_hit = io_sel && (io_addr == ewsg_pkg::WSC_ADDR);  // see RULE6
      cfg_d   = cfg_q;
      if (cfg_hit && io_wr)
      begin
         cfg_d = io_wdata[ewsg_pkg::IMPL_BITS-1:0];  // see RULE2
      end
   end

   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         cfg_q <= ewsg_pkg::WSC_RESET;  // see RULE5 see RULE11
      end
      else
      begin
         cfg_q <= cfg_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // read data, registered; reserved bits zero
   logic [15:0] rdata_q, rdata_d;

   always_comb
   begin
      rdata_d = 16'h0000;
      if (cfg_hit && !io_wr)
      begin
         rdata_d = {5'h00, cfg_q};  // see RULE16
      end
   end

   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         rdata_q <= 16'h0000;
      end
      else
      begin
         rdata_q <= rdata_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // ready pin synchroniser: three stages, change when stages 2 and 3 agree
   logic rdy_s1_q, rdy_s2_q, rdy_s3_q, rdy_q;
   logic rdy_d;

   always_comb
   begin
      rdy_d = rdy_q;
      if (rdy_s2_q == rdy_s3_q)
      begin
         rdy_d = rdy_s3_q;
      end
   end

   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         rdy_s1_q <= 1'b1;
         rdy_s2_q <= 1'b1;
         rdy_s3_q <= 1'b1;
         rdy_q    <= 1'b1;
      end
      else
      begin
         rdy_s1_q <= ready_pin;
         rdy_s2_q <= rdy_s1_q;
         rdy_s3_q <= rdy_s2_q;
         rdy_q    <= rdy_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // wait-state sequencer
   // fields are sampled at start, so a write mid-access only hits the next one
   ewsg_pkg::ewsg_state_t st_q, st_d;
   logic [2:0]            cnt_q, cnt_d;
   logic [2:0]            sel_waits;
   logic                  busy_d, done_d;
   logic                  busy_q, done_q;

   always_comb
   begin
      unique case (ext_space)
         ewsg_pkg::SPACE_DATA: sel_waits = cfg_q[ewsg_pkg::DSW_LSB +: ewsg_pkg::WAIT_W];  // see RULE9
         ewsg_pkg::SPACE_IO:   sel_waits = cfg_q[ewsg_pkg::ISW_LSB +: ewsg_pkg::WAIT_W];  // see RULE10
         default:              sel_waits = cfg_q[ewsg_pkg::PSW_LSB +: ewsg_pkg::WAIT_W];  // see RULE8
      endcase
      st_d   = st_q;
      cnt_d  = cnt_q;
      busy_d = 1'b0;
      done_d = 1'b0;
      unique case (st_q)
         ewsg_pkg::EWSG_IDLE:
         begin
            if (ext_start)
            begin
               cnt_d  = sel_waits;  // see RULE7 see RULE17
               busy_d = 1'b1;
               st_d   = ewsg_pkg::EWSG_WAIT;
            end
         end
         ewsg_pkg::EWSG_WAIT:
         begin
            busy_d = 1'b1;
            // programmed count runs regardless of ready; ready only extends
            if (cnt_q != ewsg_pkg::WAIT_ZERO)
            begin
               cnt_d = cnt_q - 3'h1;  // see RULE3 see RULE1
            end
            else if (rdy_q)
            begin
               busy_d = 1'b0;
               done_d = 1'b1;
               st_d   = ewsg_pkg::EWSG_DONE;
            end  // see RULE4
         end
         ewsg_pkg::EWSG_DONE:
         begin
            st_d = ewsg_pkg::EWSG_IDLE;
         end
         default:
         begin
            st_d = ewsg_pkg::EWSG_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         st_q   <= ewsg_pkg::EWSG_IDLE;
         cnt_q  <= ewsg_pkg::WAIT_ZERO;
         busy_q <= 1'b0;
         done_q <= 1'b0;
      end
      else
      begin
         st_q   <= st_d;
         cnt_q  <= cnt_d;
         busy_q <= busy_d;
         done_q <= done_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // bus visibility mux
   logic [15:0] va_q, va_d, vd_q, vd_d;
   logic        voe_q, voe_d;

   always_comb
   begin
      va_d  = 16'h0000;
      vd_d  = 16'h0000;
      voe_d = 1'b0;
      // visibility never fights a real external cycle
      if (int_exec && !busy_d && cfg_q[ewsg_pkg::BUS_VISIBILITY_SELECT_EN_BIT])  // see RULE12 see RULE13
      begin
         voe_d = 1'b1;
         if (cfg_q[ewsg_pkg::BUS_VISIBILITY_SELECT_PROG_BIT])
         begin
            va_d = prog_addr;  // see RULE15
            vd_d = prog_data;
         end
         else
         begin
            va_d = data_addr;  // see RULE14
            vd_d = data_data;
         end
      end
   end

   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         va_q  <= 16'h0000;
         vd_q  <= 16'h0000;
         voe_q <= 1'b0;
      end
      else
      begin
         va_q  <= va_d;
         vd_q  <= vd_d;
         voe_q <= voe_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // outputs
   always_comb
   begin
      io_rdata              = rdata_q;
      ext_busy              = busy_q;
      ext_done              = done_q;
      vis_addr              = va_q;
      vis_data              = vd_q;
      vis_oe                = voe_q;
      program_space_waits   = cfg_q[ewsg_pkg::PSW_LSB +: ewsg_pkg::WAIT_W];
      data_space_waits      = cfg_q[ewsg_pkg::DSW_LSB +: ewsg_pkg::WAIT_W];
      io_space_waits        = cfg_q[ewsg_pkg::ISW_LSB +: ewsg_pkg::WAIT_W];
      bus_visibility_select = cfg_q[ewsg_pkg::BUS_VISIBILITY_SELECT_LSB +: 2];
   end

endmodule
`default_nettype wire

// ### ewsg_props.sv
`timescale 1ns/100ps
`default_nettype none
module ewsg_props
(
   // clock and reset
   input wire logic        clock,
   input wire logic        reset,
   // register port
   input wire logic        io_sel,
   input wire logic        io_wr,
   input wire logic [15:0] io_addr,
   input wire logic [15:0] io_wdata,
   input wire logic [15:0] io_rdata,
   // access
   input wire logic        ext_start,
   input wire logic [1:0]  ext_space,
   input wire logic        ext_busy,
   input wire logic        ext_done,
   // visibility
   input wire logic        int_exec,
   input wire logic [15:0] prog_addr,
   input wire logic [15:0] vis_addr,
   input wire logic        vis_oe,
   // fields
   input wire logic [2:0]  program_space_waits,
   input wire logic [2:0]  data_space_waits,
   input wire logic [2:0]  io_space_waits,
   input wire logic [1:0]  bus_visibility_select
);
   wire logic [10:0] cfg = {bus_visibility_select, io_space_waits, data_space_waits,
                            program_space_waits};
   wire logic        take = io_sel && io_addr == 16'hffff;
   wire logic        go = ext_start && !ext_busy && !ext_done;
   logic [2:0]       n_q, n_d;
   logic [3:0]       c_q, c_d;
   // count saturates so long stalls never wrap
   always_comb
   begin
      n_d = go ? (ext_space == 2'h1 ? data_space_waits : ext_space == 2'h2 ? io_space_waits
            : program_space_waits) : n_q;
      c_d = go ? 4'h1 : (c_q == 4'hf ? c_q : c_q + 4'h1);
   end
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         n_q <= 3'h0;
         c_q <= 4'h0;
      end
      else
      begin
         n_q <= n_d;
         c_q <= c_d;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   default clocking @(posedge clock); endclocking
   default disable iff (reset);
   property p_rd; take && !io_wr |=> io_rdata == {5'h00, $past(cfg)}; endproperty
   a_rd: assert property (p_rd) else $error("config read wrong");
   property p_map; !(take && !io_wr) |=> io_rdata == 16'h0000; endproperty
   a_map: assert property (p_map) else $error("stray read data");
   property p_wr; take && io_wr |=> cfg == $past(io_wdata[10:0]); endproperty
   a_wr: assert property (p_wr) else $error("config write lost");
   property p_go; go |=> ext_busy; endproperty
   a_go: assert property (p_go) else $error("access not started");
   property p_min; ext_done |-> c_q >= n_q + 4'h2; endproperty
   a_min: assert property (p_min) else $error("access too short");
   property p_pulse; ext_done |=> !ext_done && !ext_busy; endproperty
   a_pulse: assert property (p_pulse) else $error("done not a pulse");
   property p_off; !bus_visibility_select[1] |=> !vis_oe; endproperty
   a_off: assert property (p_off) else $error("visibility while off");
   property p_int; !int_exec |=> !vis_oe; endproperty
   a_int: assert property (p_int) else $error("visibility outside internal run");
   property p_prog;
      int_exec && bus_visibility_select == 2'h3 && !ext_busy && !ext_start && !ext_done
      |=> vis_oe && vis_addr == $past(prog_addr);
   endproperty
   a_prog: assert property (p_prog) else $error("program bus not shown");
   c_go: cover property (go);
   c_long: cover property (ext_done && c_q > 4'h9);
   c_vis: cover property (vis_oe);
endmodule
bind ewsg_wait_state_gen ewsg_props u_props (.clock, .reset, .io_sel, .io_wr, .io_addr,
   .io_wdata, .io_rdata, .ext_start, .ext_space, .ext_busy, .ext_done, .int_exec, .prog_addr,
   .vis_addr, .vis_oe, .program_space_waits, .data_space_waits, .io_space_waits,
   .bus_visibility_select);
`default_nettype wire

// ### ewsg_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
module ewsg_mem_model
(
   // clock and reset
   input  wire logic       clock,
   input  wire logic       reset,
   // access seen, extra cycles asked
   input  wire logic       ext_busy,
   input  wire logic [3:0] stall,
   // ready back to device
   output var  logic       ready_pin
);
   logic [3:0] cnt_q, cnt_d;
   always_comb
   begin
      cnt_d = ext_busy ? (cnt_q == 4'hf ? cnt_q : cnt_q + 4'h1) : 4'h0;
   end
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
         cnt_q <= 4'h0;
      else
         cnt_q <= cnt_d;
   end
   // pull-up holds ready high between accesses
   assign ready_pin = !(ext_busy && cnt_q < stall);
endmodule
`default_nettype wire

// ### tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin err_count++; \
   $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb_top;
   logic        clock = 1'b0, reset = 1'b1, io_sel, io_wr, ext_start, int_exec;
   logic        ext_busy, ext_done, ready_pin, vis_oe;
   logic [15:0] io_addr, io_wdata, io_rdata, prog_addr, prog_data, data_addr, data_data;
   logic [15:0] vis_addr, vis_data;
   logic [2:0]  program_space_waits, data_space_waits, io_space_waits;
   logic [1:0]  ext_space, bus_visibility_select;
   logic [3:0]  stall;
   int          err_count = 0, cmp_count = 0, len;
   always #2 clock = ~clock;
   ewsg_wait_state_gen uut (.clock, .reset, .io_sel, .io_wr, .io_addr, .io_wdata, .io_rdata,
      .ext_start, .ext_space, .ext_busy, .ext_done, .ready_pin, .int_exec, .prog_addr,
      .prog_data, .data_addr, .data_data, .vis_addr, .vis_data, .vis_oe, .program_space_waits,
      .data_space_waits, .io_space_waits, .bus_visibility_select);
   ewsg_mem_model mem (.clock, .reset, .ext_busy, .stall, .ready_pin);
   ////////////////////////////////////////////////////////////////////////////////
   task automatic summarize;
      $display("checks %0d errors %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic io(input logic w, input logic [15:0] a, input logic [15:0] d);
      @(posedge clock);
      io_sel <= 1'b1;
      io_wr <= w;
      io_addr <= a;
      io_wdata <= d;
      @(posedge clock);
      io_sel <= 1'b0;
      #1;
   endtask
   // len counts edges from the taking edge to done
   task automatic go(input logic [1:0] s);
      @(posedge clock);
      ext_start <= 1'b1;
      ext_space <= s;
      @(posedge clock);
      ext_start <= 1'b0;
      len = 0;
      do
      begin
         @(posedge clock);
         #1;
         len++;
         if (len > 60)
         begin
            err_count++;
            summarize();
         end
      end
      while (ext_done !== 1'b1);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      {io_sel, io_wr, ext_start, int_exec, ext_space, stall, io_addr, io_wdata} = '0;
      {prog_addr, prog_data, data_addr, data_data} = 64'h1234_5678_9abc_def0;
      repeat (12) @(posedge clock);
      reset <= 1'b0;
      io(1'b1, 16'hfffe, 16'h0000);
      io(1'b0, 16'hffff, 16'h0000);
      `CHK("reset cfg", 16'h07ff, io_rdata)
      io(1'b0, 16'hfffe, 16'h0000);
      `CHK("unmapped", 16'h0000, io_rdata)
      io(1'b1, 16'hffff, 16'hffff);
      io(1'b0, 16'hffff, 16'h0000);
      `CHK("reserved", 16'h07ff, io_rdata)
      for (int n = 0; n < 8; n++)
      begin
         io(1'b1, 16'hffff, {7'h00, 3'(n + 3), 3'(7 - n), 3'(n)});
         go(2'h0);
         `CHK("prog len", n + 1, len)
         go(2'h1);
         `CHK("data len", 8 - n, len)
         go(2'h2);
         `CHK("io len", (n + 3) % 8 + 1, len)
      end
      // ready passes a 3-flop sync, so only waits past its latency can be stretched
      io(1'b1, 16'hffff, 16'h0028);
      @(posedge clock);
      stall <= 4'ha;
      go(2'h1);
      `CHK("stretched", 1'b1, len > 10)
      io(1'b1, 16'hffff, 16'h003f);
      @(posedge clock);
      stall <= 4'h2;
      go(2'h0);
      `CHK("ready early", 8, len)
      @(posedge clock);
      int_exec <= 1'b1;
      for (int b = 0; b < 4; b++)
      begin
         io(1'b1, 16'hffff, {5'h00, 2'(b), 9'h000});
         @(posedge clock);
         #1;
         `CHK("vis oe", 1'(b > 1), vis_oe)
         if (b > 1)
         begin
            `CHK("vis addr", b[0] ? prog_addr : data_addr, vis_addr)
            `CHK("vis data", b[0] ? prog_data : data_data, vis_data)
         end
      end
      @(posedge clock);
      int_exec <= 1'b0;
      repeat (2) @(posedge clock);
      #1;
      `CHK("vis ext run", 1'b0, vis_oe)
      summarize();
   end
endmodule
`default_nettype wire
